/* File: afrs_pkg.sv */
// Package for the amplifier fault and restart sequencer.
// Assumes a single 125 MHz clock domain; imported by the sequencer, its checker and the bench.
package afrs_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 125;
  localparam int RESTART_MS = 100;
  localparam longint RESTART_CYC = longint'(RESTART_MS) * 1000 * CLK_MHZ;
  localparam int TMR_W = 24;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_FAULTS = 8'h10;

  // Control fields
  localparam int CTRL_SYM_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Fault vector positions
  localparam int FLT_N = 7;
  localparam int F_UV = 0;
  localparam int F_OV = 1;
  localparam int F_UB = 2;
  localparam int F_OT = 3;
  localparam int F_OC = 4;
  localparam int F_WIN = 5;
  localparam int F_EXT = 6;
  // Faults that retry on the 100 ms timer
  localparam logic [FLT_N-1:0] RETRY_MASK = 7'h0F;

  // Interrupt event positions
  localparam int EV_N = 4;
  localparam int EV_SHUT = 0;
  localparam int EV_RESTART = 1;
  localparam int EV_EXTREQ = 2;
  localparam int EV_FOLD = 3;

  typedef enum logic [1:0] {MD_SLEEP, MD_MUTE, MD_OPER, MD_FAULT} afrs_mode_t;
endpackage : afrs_pkg

/* File: afrs_sync.sv */
// Two-flop synchroniser bank for asynchronous fault and pin inputs.
// Assumes inputs are quasi-static levels from analog comparators or pins.
`timescale 1ns/1ps
module afrs_sync #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_r;

  // Reset to zero: all inputs here are active-high requests
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_r <= '0;
      syncOut <= '0;
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule : afrs_sync

/* File: afrs_timer.sv */
// Restart delay timer for the fault sequencer.
// Assumes load pulses come from the same clock domain.
`timescale 1ns/1ps
module afrs_timer #(
  parameter int W = 24,
  parameter logic [W-1:0] LOAD_VAL = '1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic load,
  input wire logic run,
  output logic expired
);
  logic [W-1:0] cnt_r;

  // Reload wins over counting so a repeated fault restarts the wait
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= LOAD_VAL;
    end else if (run && cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign expired = run && !load && (cnt_r == '0);
endmodule : afrs_timer

/* File: afrs_seq.sv */
// Fault management and restart sequencer for a class-D amplifier.
// Assumes one 125 MHz clock, synchronous reset, comparator levels from
// the analog side, and an AHB-Lite master as the only bus master.
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module afrs_seq
  import afrs_pkg::*;
#(
  parameter logic [TMR_W-1:0] RESTART_CYCLES = TMR_W'(RESTART_CYC - 1)
) (
  input wire logic mclk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Mode pins
  input wire logic powerOnRequest,
  input wire logic unmuteRequest,
  // Open-drain fault indicator pin
  input wire logic faultIndicatorPinIn,
  output logic faultIndicatorPinOut,
  output logic faultIndicatorPinOe,
  // Comparator indications
  input wire logic undervoltageFault,
  input wire logic overvoltageFault,
  input wire logic unbalanceWindowOut,
  input wire logic unbalanceRelease,
  input wire logic overtempFault,
  input wire logic overcurrentLoadShort,
  input wire logic overcurrentRailShort,
  input wire logic outputWindowFault,
  input wire logic thermalGainFoldback,
  input wire logic refChargedIn,
  // Power stage controls
  output logic powerStageEn,
  output logic idleSwitching,
  output logic inputStageEn,
  output logic halfSupplyBufEn,
  output logic [1:0] modeOut,
  output logic irq
);
  localparam int NS = 13;
  logic [NS-1:0] rawIn;
  logic [NS-1:0] syncIn;
  logic sUv, sOv, sUbWin, sUbRel, sOt, sOcLoad, sOcRail, sWin, sFold, sCharged;
  logic sPwr, sUnmute, sPinLow;

  // Every outside level passes two flops first
  assign rawIn = {undervoltageFault, overvoltageFault, unbalanceWindowOut,
                  unbalanceRelease, overtempFault, overcurrentLoadShort,
                  overcurrentRailShort, outputWindowFault, thermalGainFoldback,
                  refChargedIn, powerOnRequest, unmuteRequest, !faultIndicatorPinIn};
  afrs_sync #(.W(NS)) uSync (
    .mclk(mclk),
    .srst(srst),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );
  assign {sUv, sOv, sUbWin, sUbRel, sOt, sOcLoad, sOcRail, sWin, sFold,
          sCharged, sPwr, sUnmute, sPinLow} = syncIn;

  // Register bank
  logic [31:0] ctrl_r;
  logic [EV_N-1:0] irqStat_r, irqMask_r, evSet;
  logic symSupply;
  assign symSupply = ctrl_r[CTRL_SYM_BIT];

  // Unbalance latch: set by window, cleared by release level when symmetrical
  logic ubLatch_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      ubLatch_r <= 1'b0;
    end else if (sUbWin) begin
      ubLatch_r <= 1'b1;
    end else if (!symSupply || sUbRel) begin
      ubLatch_r <= 1'b0;
    end
  end

  // Active fault vector
  logic [FLT_N-1:0] faults;
  logic sPinExt;
  assign faults[F_UV] = sUv;
  assign faults[F_OV] = sOv;
  assign faults[F_UB] = ubLatch_r;
  assign faults[F_OT] = sOt;
  assign faults[F_OC] = sOcRail;
  assign faults[F_WIN] = sWin;
  assign faults[F_EXT] = sPinExt;

  // Sequencer
  typedef enum logic [2:0] {ST_SLEEP, ST_CHARGE, ST_CHECK, ST_RUN, ST_SHUT, ST_WAIT}
    afrs_state_t;
  afrs_state_t state_r;
  logic [FLT_N-1:0] cause_r;
  logic loadShort_r;
  logic anyFault, tmrLoad, tmrRun, tmrDone;
  assign anyFault = (|faults) || sOcLoad;

  // Wait policy: retry faults and load short use the timer, others wait for removal
  logic retryCause, retryFaultNow;
  assign retryCause = (|(cause_r & RETRY_MASK)) || loadShort_r;
  // Load short reloads too, so a persisting short keeps the stage off
  assign retryFaultNow = (|(faults & RETRY_MASK)) || sOcLoad;

  // Reload timer on entry and whenever a retry fault is still present
  assign tmrLoad = (state_r == ST_SHUT) || (state_r == ST_WAIT && retryFaultNow);
  assign tmrRun = (state_r == ST_WAIT);

  afrs_timer #(.W(TMR_W), .LOAD_VAL(RESTART_CYCLES)) uTmr (
    .mclk(mclk),
    .srst(srst),
    .load(tmrLoad),
    .run(tmrRun),
    .expired(tmrDone)
  );

  // Non-retry faults must also be gone before leaving the wait
  logic waitDone;
  always_comb begin
    if (retryCause) begin
      waitDone = tmrDone && !(|faults);
    end else begin
      waitDone = !(|faults);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_SLEEP;
      cause_r <= '0;
      loadShort_r <= 1'b0;
    end else begin
      case (state_r)
        ST_SLEEP: begin
          if (sPwr) begin
            state_r <= ST_CHARGE;
          end
        end
        ST_CHARGE: begin
          if (!sPwr) begin
            state_r <= ST_SLEEP;
          end else if (sCharged) begin
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (!sPwr) begin
            state_r <= ST_SLEEP;
          end else if (anyFault) begin
            state_r <= ST_SHUT;
            cause_r <= faults;
            loadShort_r <= sOcLoad;
          end else begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!sPwr) begin
            state_r <= ST_SLEEP;
          end else if (anyFault) begin
            state_r <= ST_SHUT;
            cause_r <= faults;
            loadShort_r <= sOcLoad;
          end
        end
        ST_SHUT: begin
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (!sPwr) begin
            state_r <= ST_SLEEP;
          end else if (waitDone) begin
            state_r <= ST_CHECK; // restart re-runs the output check
          end
        end
        default: begin
          state_r <= ST_SLEEP;
        end
      endcase
    end
  end

  // Pin output: protections other than foldback pull it low
  logic protActive, pinDrive_r;
  assign protActive = (state_r == ST_SHUT) || (state_r == ST_WAIT) || anyFault;
  always_ff @(posedge mclk) begin
    if (srst) begin
      pinDrive_r <= 1'b0;
    end else begin
      pinDrive_r <= protActive && sPwr;
    end
  end
  assign faultIndicatorPinOut = 1'b0;
  assign faultIndicatorPinOe = !pinDrive_r;

  // Own low drive is masked so a self-pulled pin does not latch the fault
  logic pinDriveD1_r, pinDriveD2_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      pinDriveD1_r <= 1'b0;
      pinDriveD2_r <= 1'b0;
    end else begin
      pinDriveD1_r <= pinDrive_r;
      pinDriveD2_r <= pinDriveD1_r;
    end
  end
  assign sPinExt = sPinLow && !pinDrive_r && !pinDriveD1_r && !pinDriveD2_r;

  // Mode decode from pins and sequencer
  afrs_mode_t mode;
  always_comb begin
    if (!sPwr) begin
      mode = MD_SLEEP;
    end else if (sPinLow || state_r == ST_SHUT || state_r == ST_WAIT) begin
      mode = MD_FAULT;
    end else if (sUnmute) begin
      mode = MD_OPER;
    end else begin
      mode = MD_MUTE;
    end
  end

  // Output controls, registered
  logic running;
  assign running = (state_r == ST_RUN) && !anyFault;
  always_ff @(posedge mclk) begin
    if (srst) begin
      powerStageEn <= 1'b0;
      idleSwitching <= 1'b0;
      inputStageEn <= 1'b0;
      halfSupplyBufEn <= 1'b0;
      modeOut <= 2'(MD_SLEEP);
    end else begin
      powerStageEn <= running && (mode != MD_FAULT);
      idleSwitching <= running && mode == MD_MUTE;
      inputStageEn <= running && mode == MD_OPER;
      halfSupplyBufEn <= sPwr && !symSupply;
      modeOut <= 2'(mode);
    end
  end

  // Interrupt events
  logic fold_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      fold_r <= 1'b0;
    end else begin
      fold_r <= sFold;
    end
  end
  always_comb begin
    evSet = '0;
    evSet[EV_SHUT] = (state_r == ST_SHUT);
    evSet[EV_RESTART] = (state_r == ST_WAIT) && waitDone && sPwr;
    evSet[EV_EXTREQ] = sPinExt;
    evSet[EV_FOLD] = sFold && !fold_r;
  end

  // AHB-Lite: zero wait states, always OKAY
  logic aValid, aWrite_r, aPend_r;
  logic [7:0] aAddr_r;
  assign aValid = hsel && htrans[1] && hready;
  always_ff @(posedge mclk) begin
    if (srst) begin
      aPend_r <= 1'b0;
      aWrite_r <= 1'b0;
      aAddr_r <= '0;
    end else begin
      aPend_r <= aValid;
      aWrite_r <= hwrite;
      aAddr_r <= haddr;
    end
  end
  logic wrEn;
  assign wrEn = aPend_r && aWrite_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Writable registers; set wins over write-one-to-clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_r <= CTRL_RST;
      irqMask_r <= '0;
      irqStat_r <= '0;
    end else begin
      if (wrEn && aAddr_r == OFS_CTRL) begin
        ctrl_r <= hwdata;
      end
      if (wrEn && aAddr_r == OFS_IRQ_MASK) begin
        irqMask_r <= hwdata[EV_N-1:0];
      end
      if (wrEn && aAddr_r == OFS_IRQ_STAT) begin
        irqStat_r <= (irqStat_r & ~hwdata[EV_N-1:0]) | evSet;
      end else begin
        irqStat_r <= irqStat_r | evSet;
      end
    end
  end

  // Read mux; unmapped reads zero
  always_comb begin
    hrdata = '0;
    if (aPend_r && !aWrite_r) begin
      case (aAddr_r)
        OFS_CTRL: hrdata = ctrl_r;
        OFS_STAT: hrdata = {24'h000000, 1'b0, 3'(state_r), 2'(mode), pinDrive_r, sFold};
        OFS_IRQ_STAT: hrdata = {28'h0000000, irqStat_r};
        OFS_IRQ_MASK: hrdata = {28'h0000000, irqMask_r};
        OFS_FAULTS: hrdata = {24'h000000, sOcLoad, faults};
        default: hrdata = '0;
      endcase
    end
  end

  assign irq = |(irqStat_r & irqMask_r);
endmodule : afrs_seq

/* File: afrs_seq_sva.sv */
// Port-level checker for the amplifier fault and restart sequencer.
// Assumes one clock domain and binding onto afrs_seq.
`timescale 1ns/1ps
module afrs_seq_chk
  import afrs_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic powerOnRequest,
  input wire logic faultIndicatorPinIn,
  input wire logic undervoltageFault,
  input wire logic refChargedIn,
  input wire logic faultIndicatorPinOut,
  input wire logic faultIndicatorPinOe,
  input wire logic powerStageEn,
  input wire logic idleSwitching,
  input wire logic inputStageEn,
  input wire logic [1:0] modeOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Pin may only sink, never source
  a_pin_sink_only: assert property (faultIndicatorPinOut == 1'b0)
    else $error("indicator pin driven high");
  // Undervoltage in run stops the stage within the sync and state latency
  a_uv_stage_off: assert property ($rose(undervoltageFault) && powerStageEn
    |-> ##[1:8] !powerStageEn) else $error("stage not shut on undervoltage");
  a_uv_pin_low: assert property ($rose(undervoltageFault) && powerStageEn
    |-> ##[1:8] !faultIndicatorPinOe) else $error("pin not pulled on fault");
  a_uv_restart_hold: assert property ($fell(undervoltageFault) && !powerStageEn
    |-> !powerStageEn[*8]) else $error("restart too early");
  a_sleep_decode: assert property (!powerOnRequest[*8]
    |-> modeOut == MD_SLEEP && !powerStageEn) else $error("not asleep");
  a_ext_fault_mode: assert property ((powerOnRequest && !faultIndicatorPinIn)[*8]
    |-> modeOut == MD_FAULT && !powerStageEn) else $error("pin low without fault mode");
  a_start_charged: assert property ($rose(powerStageEn) |-> $past(refChargedIn, 3))
    else $error("switching before charge");
  a_mute_inputs_off: assert property (idleSwitching |-> !inputStageEn)
    else $error("input stage on in mute");
  c_shutdown: cover property ($fell(powerStageEn));
  c_fault_mode: cover property (modeOut == MD_FAULT);
  c_operating: cover property (modeOut == MD_OPER);
endmodule : afrs_seq_chk

bind afrs_seq afrs_seq_chk u_chk (.mclk, .srst, .powerOnRequest, .faultIndicatorPinIn,
  .undervoltageFault, .refChargedIn, .faultIndicatorPinOut, .faultIndicatorPinOe,
  .powerStageEn, .idleSwitching, .inputStageEn, .modeOut);

/* File: afrs_ctrl_model.sv */
// System controller model: mode pins and an external pull on the indicator pin.
// Assumes the bench steers it with level commands.
`timescale 1ns/1ps
module afrs_ctrl_model (
  input wire logic mclk,
  input wire logic wantPower,
  input wire logic wantUnmute,
  input wire logic wantFault,
  input wire logic pinOeDevice,
  output logic powerOnRequest = 1'b0,
  output logic unmuteRequest = 1'b0,
  output logic pinLevel
);
  logic extPull = 1'b0;
  // Commands land one edge late, as a slow controller would
  always @(posedge mclk) begin
    powerOnRequest <= wantPower;
    unmuteRequest <= wantUnmute;
    extPull <= wantFault;
  end
  // Wired low; weak pull-up wins only when nobody sinks
  assign pinLevel = (pinOeDevice !== 1'b0) & ~extPull;
endmodule : afrs_ctrl_model

/* File: afrs_seq_tb.sv */
// Self-checking bench for the fault and restart sequencer.
// Assumes the controller model, the bound checker and a short restart count.
`timescale 1ns/1ps
module afrs_seq_tb;
  import afrs_pkg::*;
  localparam int RC = 50;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] flt = 8'h00;
  logic ubRel = 1'b0;
  logic refChg = 1'b0;
  logic wPwr = 1'b0;
  logic wUnm = 1'b0;
  logic wFlt = 1'b0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, pinOut, pinOe, pinLvl, pwrReq, unmReq, pse, idle, ise, hbe, irq;
  logic [1:0] mode;
  int err_total = 0;
  int samples_checked = 0;
  int n;

  afrs_seq #(.RESTART_CYCLES(TMR_W'(RC - 1))) dut (.mclk, .srst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .powerOnRequest(pwrReq), .unmuteRequest(unmReq), .faultIndicatorPinIn(pinLvl),
    .faultIndicatorPinOut(pinOut), .faultIndicatorPinOe(pinOe),
    .undervoltageFault(flt[0]), .overvoltageFault(flt[1]), .unbalanceWindowOut(flt[2]),
    .unbalanceRelease(ubRel), .overtempFault(flt[3]), .overcurrentLoadShort(flt[4]),
    .overcurrentRailShort(flt[5]), .outputWindowFault(flt[6]),
    .thermalGainFoldback(flt[7]), .refChargedIn(refChg), .powerStageEn(pse),
    .idleSwitching(idle), .inputStageEn(ise), .halfSupplyBufEn(hbe), .modeOut(mode), .irq);
  afrs_ctrl_model u_ctrl (.mclk, .wantPower(wPwr), .wantUnmute(wUnm), .wantFault(wFlt),
    .pinOeDevice(pinOe), .powerOnRequest(pwrReq), .unmuteRequest(unmReq), .pinLevel(pinLvl));

  // 125 MHz clock
  initial forever #4 mclk = ~mclk;

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  // Single AHB-Lite word transfer; called just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask : cyc

  // Bounded wait for the stage enable; n holds the cycles spent
  task automatic wait_pse(input logic v, input int lim);
    n = 0;
    while (pse !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_pse

  task automatic t_reset();
    chk("mode", mode, 2'h0);
    chk("oe", pinOe, 1'b1);
    chk("pin out", pinOut, 1'b0);
    chk("hresp", hresp, 1'b0);
    chk("hreadyout", hreadyout, 1'b1);
    chk("irq", irq, 1'b0);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", q, CTRL_RST);
    bus(1'b1, OFS_IRQ_MASK, 32'hF);
    $display("test reset done");
  endtask : t_reset

  task automatic t_power_on_request();
    wPwr <= 1'b1;
    cyc(20);
    chk("pse", pse, 1'b0);
    chk("hbe", hbe, 1'b1);
    refChg <= 1'b1;
    wait_pse(1'b1, 20);
    cyc(2);
    chk("idle", idle, 1'b1);
    chk("mode", mode, MD_MUTE);
    wUnm <= 1'b1;
    cyc(8);
    chk("mode", mode, MD_OPER);
    chk("ise", ise, 1'b1);
    $display("test power_on_request done");
  endtask : t_power_on_request

  // Timed-retry faults, each re-asserted mid-wait to force a reload
  task automatic t_retry();
    int fb[5] = '{0, 1, 2, 3, 7};
    for (int i = 0; i < 5; i++) begin
      flt[i] <= 1'b1;
      wait_pse(1'b0, 12);
      chk("shut", n < 12, 1'b1);
      cyc(2);
      chk("oe", pinOe, 1'b0);
      chk("irq", irq, 1'b1);
      bus(1'b0, OFS_FAULTS, 32'h0);
      chk("fault bit", q[fb[i]], 1'b1);
      flt[i] <= 1'b0;
      cyc(RC / 2);
      flt[i] <= 1'b1;
      cyc(4);
      flt[i] <= 1'b0;
      wait_pse(1'b1, RC + 30);
      chk("retry", n >= RC - 1 && n <= RC + 14, 1'b1);
      bus(1'b1, OFS_IRQ_STAT, 32'hF);
      cyc(2);
      chk("irq clr", irq, 1'b0);
    end
    $display("test retry done");
  endtask : t_retry

  // Rail short, then window fault holding the recheck
  task automatic t_removal();
    flt[5] <= 1'b1;
    wait_pse(1'b0, 12);
    flt[6] <= 1'b1;
    cyc(3 * RC);
    chk("rail held", pse, 1'b0);
    flt[5] <= 1'b0;
    cyc(RC + 20);
    chk("window held", pse, 1'b0);
    flt[6] <= 1'b0;
    wait_pse(1'b1, RC);
    chk("removal", n < RC, 1'b1);
    $display("test removal done");
  endtask : t_removal

  task automatic t_ext();
    wFlt <= 1'b1;
    cyc(8);
    chk("mode", mode, MD_FAULT);
    chk("pse", pse, 1'b0);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("ext irq", q[EV_EXTREQ], 1'b1);
    wFlt <= 1'b0;
    wait_pse(1'b1, RC + 40);
    chk("ext gone", pse, 1'b1);
    bus(1'b1, OFS_IRQ_STAT, 32'hF);
    $display("test ext done");
  endtask : t_ext

  // Foldback alone: pin stays released; mask gates irq
  task automatic t_fold();
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    flt[7] <= 1'b1;
    cyc(10);
    chk("oe fold", pinOe, 1'b1);
    chk("pse fold", pse, 1'b1);
    // Status: run state 3, operating mode, pin released, foldback set
    bus(1'b0, OFS_STAT, 32'h0);
    chk("stat", q, 32'h0000_0039);
    chk("irq masked", irq, 1'b0);
    bus(1'b1, OFS_IRQ_MASK, 32'hF);
    cyc(2);
    chk("irq", irq, 1'b1);
    bus(1'b1, OFS_IRQ_STAT, 32'hF);
    cyc(2);
    chk("irq w1c", irq, 1'b0);
    flt[7] <= 1'b0;
    $display("test fold done");
  endtask : t_fold

  task automatic t_sym();
    bus(1'b1, OFS_CTRL, 32'h1);
    cyc(4);
    chk("hbe sym", hbe, 1'b0);
    flt[2] <= 1'b1;
    wait_pse(1'b0, 12);
    flt[2] <= 1'b0;
    cyc(RC + 30);
    chk("ub held", pse, 1'b0);
    ubRel <= 1'b1;
    wait_pse(1'b1, RC + 30);
    chk("ub release", pse, 1'b1);
    $display("test sym done");
  endtask : t_sym

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Main sequence after a ten-cycle reset
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_power_on_request();
    t_retry();
    t_removal();
    t_ext();
    t_fold();
    t_sym();
    give_verdict();
  end

  // Watchdog, well past the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    give_verdict();
  end
endmodule : afrs_seq_tb
